// ---- ledpw_pkg.sv ----
/*
 * Shared constants and types for the two-channel indicator LED PWM block.
 * Assumes a single 100 MHz clock and an APB register interface with 32-bit data.
 */
package ledpw_pkg;

  // Clock and timing
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          SLOTS_PER_PER  = 32;
  localparam int          RAMP_STEP_HZ   = 64;
  localparam int          RATE_256_MHZ   = 256_000;
  localparam int          RATE_8_MHZ     = 8_000;
  localparam int          RATE_1_MHZ     = 1_000;
  localparam int          RATE_HALF_MHZ  = 500;
  localparam int          SLOT_CYC_256   = int'((64'(CLK_HZ) * 64'd1000) /
                                                (64'(RATE_256_MHZ) * 64'(SLOTS_PER_PER)));
  localparam int          SLOT_CYC_8     = int'((64'(CLK_HZ) * 64'd1000) /
                                                (64'(RATE_8_MHZ) * 64'(SLOTS_PER_PER)));
  localparam int          SLOT_CYC_1     = int'((64'(CLK_HZ) * 64'd1000) /
                                                (64'(RATE_1_MHZ) * 64'(SLOTS_PER_PER)));
  localparam int          SLOT_CYC_HALF  = int'((64'(CLK_HZ) * 64'd1000) /
                                                (64'(RATE_HALF_MHZ) * 64'(SLOTS_PER_PER)));
  localparam int          RAMP_TICK_CYC  = CLK_HZ / RAMP_STEP_HZ;

  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_RED_CFG    = 8'h04;
  localparam logic [7:0]  OFS_GREEN_CFG  = 8'h08;
  localparam logic [7:0]  OFS_STATUS     = 8'h0C;

  // CTRL fields
  localparam int          CTRL_OVR_BIT   = 0;
  localparam int          CTRL_RED_EN    = 1;
  localparam int          CTRL_GRN_EN    = 2;

  // Channel config fields
  localparam int          CFG_DUTY_LSB   = 0;
  localparam int          CFG_LEVEL_LSB  = 6;
  localparam int          CFG_REP_LSB    = 8;
  localparam int          CFG_RAMP_BIT   = 10;

  // STATUS fields
  localparam int          ST_RED_EFF_LSB = 0;
  localparam int          ST_GRN_EFF_LSB = 8;
  localparam int          ST_THERMAL_BIT = 16;
  localparam int          ST_RED_ON_BIT  = 17;
  localparam int          ST_GRN_ON_BIT  = 18;

  // Duty encoding
  localparam logic [5:0]  DUTY_OFF       = 6'h00;
  localparam logic [5:0]  DUTY_FULL      = 6'h20;

  // Current level codes: 3.5, 7.0, 10, 12 mA
  typedef enum logic [1:0] {
    LEVEL_3MA5  = 2'b00,
    LEVEL_7MA   = 2'b01,
    LEVEL_10MA  = 2'b10,
    LEVEL_12MA  = 2'b11
  } ledpw_level_t;

  localparam ledpw_level_t LEVEL_RST     = LEVEL_7MA;

  // Repetition rates
  typedef enum logic [1:0] {
    REP_256HZ   = 2'b00,
    REP_8HZ     = 2'b01,
    REP_1HZ     = 2'b10,
    REP_HALFHZ  = 2'b11
  } ledpw_rep_t;

  localparam ledpw_rep_t REP_RST         = REP_256HZ;

  // Per-channel PWM state
  typedef struct packed {
    logic [22:0] slot_cnt;
    logic [4:0]  slot_idx;
    logic        on;
  } ledpw_pwm_st_t;

  // Top-level state; index 0 is red, index 1 is green
  typedef struct packed {
    logic                    override;
    logic [1:0]              en;
    logic [1:0][5:0]         duty;
    ledpw_level_t [1:0]      level;
    ledpw_rep_t [1:0]        rep;
    logic [1:0]              ramp;
    logic [1:0][5:0]         eff;
    logic [20:0]             tick_cnt;
    logic [2:0]              thermal_sy;
    logic                    thermal_hot;
    logic [1:0]              led_on;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } ledpw_top_st_t;

endpackage

// ---- ledpw_pwm_chan.sv ----
/*
 * One PWM channel: divides each period into 32 slots and drives the output
 * for the first n slots. Assumes the effective duty is 0..32 from the top.
 */
module ledpw_pwm_chan #(
  parameter int SLOT_256  = ledpw_pkg::SLOT_CYC_256,
  parameter int SLOT_8    = ledpw_pkg::SLOT_CYC_8,
  parameter int SLOT_1    = ledpw_pkg::SLOT_CYC_1,
  parameter int SLOT_HALF = ledpw_pkg::SLOT_CYC_HALF
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire ledpw_pkg::ledpw_rep_t rep_sel,
  input  wire logic [5:0]            duty_eff,
  output logic                       pwm_on
);

  ledpw_pkg::ledpw_pwm_st_t st_ff;
  ledpw_pkg::ledpw_pwm_st_t nxt_st;
  logic [22:0]              slot_len;

  // Slot length from repetition rate
  always_comb begin
    case (rep_sel)
      ledpw_pkg::REP_256HZ:  slot_len = 23'(SLOT_256);
      ledpw_pkg::REP_8HZ:    slot_len = 23'(SLOT_8);
      ledpw_pkg::REP_1HZ:    slot_len = 23'(SLOT_1);
      ledpw_pkg::REP_HALFHZ: slot_len = 23'(SLOT_HALF);
      default:               slot_len = 23'(SLOT_256);
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // 32 slots per period; active for the first n slots
    if (st_ff.slot_cnt >= slot_len - 23'h00_0001) begin
      nxt_st.slot_cnt = 23'h00_0000;
      nxt_st.slot_idx = st_ff.slot_idx + 5'h01;
    end else begin
      nxt_st.slot_cnt = st_ff.slot_cnt + 23'h00_0001;
    end
    nxt_st.on = ({1'b0, st_ff.slot_idx} < duty_eff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pwm_on = st_ff.on;

endmodule

// ---- ledpw_top.sv ----
/*
 * Two-channel indicator LED controller: APB registers, thermal gate input
 * synchroniser, duty ramping and per-channel PWM with blink rates.
 * Assumes a 100 MHz pclk, an APB master, and analog current sinks that
 * take the on signal and the current level code.
 */
// Operation
// - Light a channel only with its enable, override, thermal gate clear and nonzero duty.
// - Red and green are independent channels with their own level, duty, ramp and rate.
// - The 2-bit level selects 3.5, 7.0 (reset), 10 or 12 mA sink current.
// - Duty n gives n/32 on time; any value with the top bit set is continuously on.
// - Ramping applies only with the ramp bit set and the 256 Hz rate selected.
// - While ramping, effective duty steps 1/32 every 1/64 s until it reaches the target.
// - Each duty change restarts the ramp from the present effective duty.
// - With ramping off a new duty takes effect at once.
// - The 2-bit rate field gives 256, 8, 1 or 1/2 Hz periods; slow rates blink.
module ledpw_top #(
  parameter int SLOT_256  = ledpw_pkg::SLOT_CYC_256,
  parameter int SLOT_8    = ledpw_pkg::SLOT_CYC_8,
  parameter int SLOT_1    = ledpw_pkg::SLOT_CYC_1,
  parameter int SLOT_HALF = ledpw_pkg::SLOT_CYC_HALF,
  parameter int RAMP_TICK = ledpw_pkg::RAMP_TICK_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    thermal_gate,
  output logic                         red_led_output,
  output logic                         green_led_output,
  output ledpw_pkg::ledpw_level_t      red_current_level,
  output ledpw_pkg::ledpw_level_t      green_current_level
);

  ledpw_pkg::ledpw_top_st_t st_ff;
  ledpw_pkg::ledpw_top_st_t nxt_st;
  logic [1:0]               pwm_on;
  logic                     acc_first;
  logic                     acc_done;
  logic                     ramp_tick;
  logic [1:0][5:0]          target;
  logic [1:0]               ramp_act;
  logic [31:0]              rd_word;
  logic                     mapped;

  // One PWM engine per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    ledpw_pwm_chan #(
      .SLOT_256  (SLOT_256),
      .SLOT_8    (SLOT_8),
      .SLOT_1    (SLOT_1),
      .SLOT_HALF (SLOT_HALF)
    ) ledpw_pwm_chan_inst (
      .pclk     (pclk),
      .presetn  (presetn),
      .rep_sel  (st_ff.rep[ch]),
      .duty_eff (st_ff.eff[ch]),
      .pwm_on   (pwm_on[ch])
    );
  end

  // Read mux and address decode
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr)
      ledpw_pkg::OFS_CTRL: begin
        rd_word[ledpw_pkg::CTRL_OVR_BIT] = st_ff.override;
        rd_word[ledpw_pkg::CTRL_RED_EN]  = st_ff.en[0];
        rd_word[ledpw_pkg::CTRL_GRN_EN]  = st_ff.en[1];
      end
      ledpw_pkg::OFS_RED_CFG: begin
        rd_word[ledpw_pkg::CFG_DUTY_LSB +: 6]  = st_ff.duty[0];
        rd_word[ledpw_pkg::CFG_LEVEL_LSB +: 2] = st_ff.level[0];
        rd_word[ledpw_pkg::CFG_REP_LSB +: 2]   = st_ff.rep[0];
        rd_word[ledpw_pkg::CFG_RAMP_BIT]       = st_ff.ramp[0];
      end
      ledpw_pkg::OFS_GREEN_CFG: begin
        rd_word[ledpw_pkg::CFG_DUTY_LSB +: 6]  = st_ff.duty[1];
        rd_word[ledpw_pkg::CFG_LEVEL_LSB +: 2] = st_ff.level[1];
        rd_word[ledpw_pkg::CFG_REP_LSB +: 2]   = st_ff.rep[1];
        rd_word[ledpw_pkg::CFG_RAMP_BIT]       = st_ff.ramp[1];
      end
      ledpw_pkg::OFS_STATUS: begin
        rd_word[ledpw_pkg::ST_RED_EFF_LSB +: 6] = st_ff.eff[0];
        rd_word[ledpw_pkg::ST_GRN_EFF_LSB +: 6] = st_ff.eff[1];
        rd_word[ledpw_pkg::ST_THERMAL_BIT]      = st_ff.thermal_hot;
        rd_word[ledpw_pkg::ST_RED_ON_BIT]       = st_ff.led_on[0];
        rd_word[ledpw_pkg::ST_GRN_ON_BIT]       = st_ff.led_on[1];
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st    = st_ff;
    acc_first = psel & penable & ~st_ff.pready;
    acc_done  = psel & penable & st_ff.pready;

    // Thermal gate input: three stages, accept once second and third agree
    nxt_st.thermal_sy = {st_ff.thermal_sy[1:0], thermal_gate};
    if (st_ff.thermal_sy[1] == st_ff.thermal_sy[2]) begin
      nxt_st.thermal_hot = st_ff.thermal_sy[2];
    end

    // APB: one wait cycle, answer registered
    nxt_st.pready  = acc_first;
    nxt_st.pslverr = acc_first & ~mapped;
    nxt_st.prdata  = (acc_first & ~pwrite & mapped) ? rd_word : 32'h0000_0000;

    if (acc_done & pwrite) begin
      case (paddr)
        ledpw_pkg::OFS_CTRL: begin
          nxt_st.override = pwdata[ledpw_pkg::CTRL_OVR_BIT];
          nxt_st.en[0]    = pwdata[ledpw_pkg::CTRL_RED_EN];
          nxt_st.en[1]    = pwdata[ledpw_pkg::CTRL_GRN_EN];
        end
        ledpw_pkg::OFS_RED_CFG: begin
          nxt_st.duty[0]  = pwdata[ledpw_pkg::CFG_DUTY_LSB +: 6];
          nxt_st.level[0] = ledpw_pkg::ledpw_level_t'(pwdata[ledpw_pkg::CFG_LEVEL_LSB +: 2]);
          nxt_st.rep[0]   = ledpw_pkg::ledpw_rep_t'(pwdata[ledpw_pkg::CFG_REP_LSB +: 2]);
          nxt_st.ramp[0]  = pwdata[ledpw_pkg::CFG_RAMP_BIT];
        end
        ledpw_pkg::OFS_GREEN_CFG: begin
          nxt_st.duty[1]  = pwdata[ledpw_pkg::CFG_DUTY_LSB +: 6];
          nxt_st.level[1] = ledpw_pkg::ledpw_level_t'(pwdata[ledpw_pkg::CFG_LEVEL_LSB +: 2]);
          nxt_st.rep[1]   = ledpw_pkg::ledpw_rep_t'(pwdata[ledpw_pkg::CFG_REP_LSB +: 2]);
          nxt_st.ramp[1]  = pwdata[ledpw_pkg::CFG_RAMP_BIT];
        end
        default: begin
        end
      endcase
    end

    // Ramp step timer, 1/64 s
    ramp_tick = (st_ff.tick_cnt >= 21'(RAMP_TICK - 1));
    nxt_st.tick_cnt = ramp_tick ? 21'h00_0000 : st_ff.tick_cnt + 21'h00_0001;

    for (int ch = 0; ch < 2; ch++) begin
      // Top bit set means full on
      target[ch]   = st_ff.duty[ch][5] ? ledpw_pkg::DUTY_FULL : st_ff.duty[ch];
      ramp_act[ch] = st_ff.ramp[ch] & (st_ff.rep[ch] == ledpw_pkg::REP_256HZ);
      if (!ramp_act[ch]) begin
        nxt_st.eff[ch] = target[ch];
      end else if (ramp_tick && st_ff.eff[ch] < target[ch]) begin
        nxt_st.eff[ch] = st_ff.eff[ch] + 6'h01;
      end else if (ramp_tick && st_ff.eff[ch] > target[ch]) begin
        nxt_st.eff[ch] = st_ff.eff[ch] - 6'h01;
      end

      // Output gating
      nxt_st.led_on[ch] = st_ff.en[ch] & st_ff.override & ~st_ff.thermal_hot &
                          (st_ff.eff[ch] != ledpw_pkg::DUTY_OFF) & pwm_on[ch];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.level[0] <= ledpw_pkg::LEVEL_RST;
      st_ff.level[1] <= ledpw_pkg::LEVEL_RST;
      st_ff.rep[0]   <= ledpw_pkg::REP_RST;
      st_ff.rep[1]   <= ledpw_pkg::REP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata              = st_ff.prdata;
  assign pready              = st_ff.pready;
  assign pslverr             = st_ff.pslverr;
  assign red_led_output      = st_ff.led_on[0];
  assign green_led_output    = st_ff.led_on[1];
  assign red_current_level   = st_ff.level[0];
  assign green_current_level = st_ff.level[1];

endmodule

// ---- ledpw_top_properties.sv ----
/* Port checker for ledpw_top: bus answer timing, gating and level codes.
   Assumes it is bound to ledpw_top, one clock, one wait state per transfer. */
module ledpw_top_properties (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    thermal_gate,
  input wire logic                    red_led_output,
  input wire logic                    green_led_output,
  input wire ledpw_pkg::ledpw_level_t red_current_level,
  input wire ledpw_pkg::ledpw_level_t green_current_level
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("no answer in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  chk_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("error flag wrong for address");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  chk_gate_off: assert property (thermal_gate [*7]
    |-> !red_led_output && !green_led_output)
    else $error("output lit with thermal gate high");
  chk_level_red: assert property (pready && pwrite && paddr == 8'h04
    |-> ##2 red_current_level == $past(pwdata[7:6], 2))
    else $error("red level not applied");
  chk_level_green: assert property (pready && pwrite && paddr == 8'h08
    |-> ##2 green_current_level == $past(pwdata[7:6], 2))
    else $error("green level not applied");
  chk_ctrl_off: assert property (pready && pwrite && paddr == 8'h00 && !pwdata[0]
    |-> ##4 !red_led_output && !green_led_output)
    else $error("output lit without override");

  cover property (pready && pslverr);
  cover property (red_led_output && green_led_output);
  cover property (thermal_gate [*7]);
endmodule

bind ledpw_top ledpw_top_properties ledpw_top_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .thermal_gate(thermal_gate), .red_led_output(red_led_output),
  .green_led_output(green_led_output), .red_current_level(red_current_level),
  .green_current_level(green_current_level)
);

// ---- ledpw_led_model.sv ----
/* Two indicator LEDs on current sinks: counts lit clock cycles per channel.
   Assumes clr is a one-cycle pulse from the bench. */
module ledpw_led_model (
  input  wire logic   pclk,
  input  wire logic   clr,
  input  wire logic   red_on,
  input  wire logic   green_on,
  output logic [15:0] cnt_r,
  output logic [15:0] cnt_g
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk) begin
    cnt_r <= clr ? 16'h0000 : cnt_r + 16'(red_on);
    cnt_g <= clr ? 16'h0000 : cnt_g + 16'(green_on);
  end
endmodule

// ---- ledpw_top_tb.sv ----
/* Self-checking bench for ledpw_top with short slot and ramp counts.
   Assumes the checker is bound and the LED model counts lit cycles. */
module ledpw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    pclk, presetn, psel, penable, pwrite, thermal_gate, clr;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, q;
  logic                    pready, pslverr, red_led_output, green_led_output, e;
  ledpw_pkg::ledpw_level_t red_current_level, green_current_level;
  logic [15:0]             cnt_r, cnt_g;
  int                      miscompares, tests_run;

  always #5 pclk = ~pclk;

  ledpw_top #(.SLOT_256(4), .SLOT_8(8), .SLOT_1(16), .SLOT_HALF(32), .RAMP_TICK(20))
    ledpw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .thermal_gate(thermal_gate), .red_led_output(red_led_output),
    .green_led_output(green_led_output), .red_current_level(red_current_level),
    .green_current_level(green_current_level));
  ledpw_led_model ledpw_led_model_inst (.pclk(pclk), .clr(clr), .red_on(red_led_output),
    .green_on(green_led_output), .cnt_r(cnt_r), .cnt_g(cnt_g));

  task automatic conclude();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("mismatch apb pready expected 1 seen %b", pready);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic meas(int per, int er, int eg, string what);
    repeat (per + 40) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (per) @(posedge pclk);
    @(posedge pclk);
    check({what, " red"}, 32'(er), 32'(cnt_r));
    check({what, " green"}, 32'(eg), 32'(cnt_g));
  endtask

  task automatic t_reset();
    apb(1'b0, 8'h04, 0);
    check("red cfg reset", 32'h0000_0040, q);
    apb(1'b0, 8'h0C, 0);
    check("status reset", 32'h0000_0000, q);
    apb(1'b0, 8'h10, 0);
    check("unmapped error", 32'h1, 32'(e));
    check("green level reset", 32'h1, 32'(green_current_level));
    $display("t_reset done");
  endtask

  task automatic t_gate();
    apb(1'b1, 8'h04, 32'h0000_0050);
    apb(1'b1, 8'h00, 32'h0000_0003);
    meas(128, 64, 0, "duty16");
    thermal_gate <= 1'b1;
    meas(128, 0, 0, "thermal");
    thermal_gate <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0002);
    meas(128, 0, 0, "no override");
    apb(1'b1, 8'h00, 32'h0000_0007);
    apb(1'b1, 8'h04, 32'h0000_007F);
    meas(128, 128, 0, "full duty");
    apb(1'b1, 8'h04, 32'h0000_0040);
    meas(128, 0, 0, "zero duty");
    $display("t_gate done");
  endtask

  task automatic t_rates();
    apb(1'b1, 8'h08, 32'h0000_00C8);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, 32'h0000_0008 | (i << 6) | (i << 8));
      meas(128 << i, 32 << i, 32 << i, "rate");
      check("red level", 32'(i), 32'(red_current_level));
    end
    check("green level", 32'h3, 32'(green_current_level));
    $display("t_rates done");
  endtask

  task automatic t_ramp();
    apb(1'b1, 8'h04, 32'h0000_0040);
    apb(1'b1, 8'h04, 32'h0000_0448);
    apb(1'b0, 8'h0C, 0);
    check("ramp start", 32'h1, 32'(q[5:0] <= 6'h01));
    repeat (190) @(posedge pclk);
    apb(1'b0, 8'h0C, 0);
    check("ramp up end", 32'h8, 32'(q[5:0]));
    apb(1'b1, 8'h04, 32'h0000_0444);
    apb(1'b0, 8'h0C, 0);
    check("ramp restart", 32'h1, 32'(q[5:0] inside {6'h07, 6'h08}));
    repeat (130) @(posedge pclk);
    apb(1'b0, 8'h0C, 0);
    check("ramp down end", 32'h4, 32'(q[5:0]));
    apb(1'b1, 8'h04, 32'h0000_0554);
    apb(1'b0, 8'h0C, 0);
    check("slow rate no ramp", 32'h14, 32'(q[5:0]));
    apb(1'b1, 8'h04, 32'h0000_0041);
    apb(1'b0, 8'h0C, 0);
    check("ramp off jump", 32'h1, 32'(q[5:0]));
    $display("t_ramp done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    thermal_gate = 1'b0;
    clr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gate();
    t_rates();
    t_ramp();
    conclude();
  end
endmodule
